// ==== acw_pkg.sv ====
// Purpose: Constants and types for the converter control word decoder
// Assumes: 50 MHz clock, control word written over chip select and write strobe pins
// Notes: Function list below
// Function
// - Bits 11:10 pick power mode: normal, auto power-down, auto standby, full power-down
// - Mode 00 keeps every circuit powered all the time
// - Mode 01 powers everything down after each conversion ends
// - Mode 10 keeps reference powered; wake 7 us, 600 ns with external reference
// - Mode 11 powers all down but keeps the control word intact
// - Bit 9 picks straight binary (0) or twos complement (1)
// - Bit 8 picks external (0) or on-chip (1) reference
// - Bits 7:5 name next channel, or final channel of consecutive run
// - Bits 4:3 pick single-ended, fully differential or pseudo differential pairing
// - Bits 2:1 pick sequencer mode; only 10 opens channel-list access
// - Bit 0 picks span of reference or twice reference
// - Twelve-bit write-only word, written by select and strobe, zero after reset
// - Bits 2:1 = 10 load next write's bits 7:0 into channel list
// - Bits 2:1 = 01 update settings without restarting the running sequence
// - Bits 2:1 = 11 convert channel zero up to final channel, repeating
package acw_pkg;

	localparam int CLK_MHZ = 50;
	localparam int WORD_W = 12;
	localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;

	// Field positions in the control word
	localparam int POS_PWR_HI = 11;
	localparam int POS_PWR_LO = 10;
	localparam int POS_CODING = 9;
	localparam int POS_REF = 8;
	localparam int POS_CH_HI = 7;
	localparam int POS_CH_LO = 5;
	localparam int POS_TYPE_HI = 4;
	localparam int POS_TYPE_LO = 3;
	localparam int POS_LIST_ACC = 2;
	localparam int POS_SCAN = 1;
	localparam int POS_RANGE = 0;
	localparam int LIST_W = 8;

	// Wake-up times
	localparam int STANDBY_WAKE_NS = 7000;
	localparam int EXT_REF_WAKE_NS = 600;
	localparam int SHUTDOWN_WAKE_NS = 1000;
	localparam int STANDBY_WAKE_CYC = (STANDBY_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int EXT_REF_WAKE_CYC = (EXT_REF_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int SHUTDOWN_WAKE_CYC = (SHUTDOWN_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_W = 9;

	typedef enum logic [1:0] {
		PM_NORMAL = 2'b00,
		PM_AUTO_DOWN = 2'b01,
		PM_AUTO_STANDBY = 2'b10,
		PM_FULL_DOWN = 2'b11
	} acw_power_mode_t;

	typedef enum logic [1:0] {
		IT_SINGLE = 2'b00,
		IT_DIFF = 2'b01,
		IT_PSEUDO4 = 2'b10,
		IT_PSEUDO7 = 2'b11
	} acw_input_type_t;

	// Encoded as {list access bit, scan bit}
	typedef enum logic [1:0] {
		SQ_OFF = 2'b00,
		SQ_KEEP = 2'b01,
		SQ_LIST = 2'b10,
		SQ_CONSEC = 2'b11
	} acw_seq_mode_t;

	typedef enum logic [1:0] {
		PS_UP = 2'b00,
		PS_DOWN = 2'b01,
		PS_WAKE = 2'b10
	} acw_pwr_state_t;

endpackage

// ==== acw_pwr_if.sv ====
// Purpose: Carrier between word decoder and power sequencer
// Assumes: Single clock domain
// Notes: None
`timescale 1ns/1ns
interface acw_pwr_if;
	import acw_pkg::*;
	acw_power_mode_t mode;
	logic ref_internal;
	logic trig_fall;
	logic conv_done;
	logic core_on;
	logic ref_on;
	logic ready;
	modport ctrl (output mode, ref_internal, trig_fall, conv_done, input core_on, ref_on, ready);
	modport pwr (input mode, ref_internal, trig_fall, conv_done, output core_on, ref_on, ready);
endinterface

// ==== acw_power.sv ====
// Purpose: Power state sequencing for the converter
// Assumes: Trigger edge and conversion done come as one-cycle pulses
// Notes: Control word is held elsewhere, so power-down never loses it
`timescale 1ns/1ns
module acw_power
	import acw_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	acw_pwr_if.pwr pif
);

	acw_pwr_state_t state_q;
	logic [WAKE_W-1:0] wake_cnt_q;
	logic [WAKE_W-1:0] wake_len;

	// Standby keeps the reference alive, so only the external case is quick
	always_comb begin
		if (pif.mode == PM_AUTO_STANDBY) begin
			wake_len = pif.ref_internal ? WAKE_W'(STANDBY_WAKE_CYC) : WAKE_W'(EXT_REF_WAKE_CYC);
		end else begin
			wake_len = WAKE_W'(SHUTDOWN_WAKE_CYC);
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= PS_UP;
			wake_cnt_q <= '0;
		end else begin
			unique case (state_q)
				PS_UP: begin
					if (pif.mode == PM_FULL_DOWN) begin
						state_q <= PS_DOWN;
					end else if (pif.conv_done && pif.mode != PM_NORMAL) begin
						state_q <= PS_DOWN;
					end
				end
				PS_DOWN: begin
					if (pif.mode == PM_NORMAL || (pif.trig_fall && pif.mode != PM_FULL_DOWN)) begin
						state_q <= PS_WAKE;
						wake_cnt_q <= wake_len;
					end
				end
				PS_WAKE: begin
					if (pif.mode == PM_FULL_DOWN) begin
						state_q <= PS_DOWN;
					end else if (wake_cnt_q <= WAKE_W'(1)) begin
						state_q <= PS_UP;
					end else begin
						wake_cnt_q <= wake_cnt_q - WAKE_W'(1);
					end
				end
				default: state_q <= PS_UP;
			endcase
		end
	end

	assign pif.core_on = (state_q != PS_DOWN);
	assign pif.ref_on = pif.core_on || (pif.mode == PM_AUTO_STANDBY);
	assign pif.ready = (state_q == PS_UP);

endmodule

// ==== acw_top.sv ====
// Purpose: Control word capture, field decode, channel sequencer and power control
// Assumes: Pins are asynchronous; conv_done comes from same-clock logic
// Notes: Data bus must settle before the strobe rises, as it is sampled with it
`timescale 1ns/1ns
module acw_top
	import acw_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic [WORD_W-1:0] db,
	input wire logic conversion_trigger_n,
	input wire logic conv_done,
	output logic [WORD_W-1:0] control_word_q,
	output logic [LIST_W-1:0] channel_list_q,
	output logic coding_twos_q,
	output logic ref_internal_q,
	output logic range_double_q,
	output logic [1:0] input_type_q,
	output logic [1:0] run_mode_q,
	output logic [2:0] conv_channel_q,
	output logic [2:0] vin_pos_q,
	output logic [2:0] vin_neg_q,
	output logic vin_neg_agnd_q,
	output logic channel_illegal_q,
	output logic core_on_q,
	output logic ref_on_q,
	output logic ready_q
);

	//////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic cs_n_m, cs_n_s;
	logic wr_n_m, wr_n_s, wr_n_p;
	logic trig_m, trig_s, trig_p;
	logic [WORD_W-1:0] db_m, db_s;

	always_ff @(posedge clock) begin
		if (rst) begin
			cs_n_m <= 1'b1;
			cs_n_s <= 1'b1;
			wr_n_m <= 1'b1;
			wr_n_s <= 1'b1;
			wr_n_p <= 1'b1;
			trig_m <= 1'b1;
			trig_s <= 1'b1;
			trig_p <= 1'b1;
			db_m <= '0;
			db_s <= '0;
		end else begin
			cs_n_m <= cs_n;
			cs_n_s <= cs_n_m;
			wr_n_m <= wr_n;
			wr_n_s <= wr_n_m;
			wr_n_p <= wr_n_s;
			trig_m <= conversion_trigger_n;
			trig_s <= trig_m;
			trig_p <= trig_s;
			db_m <= db;
			db_s <= db_m;
		end
	end

	logic wr_take;
	logic trig_fall;
	assign wr_take = !wr_n_p && wr_n_s && !cs_n_s;
	assign trig_fall = trig_p && !trig_s;

	//////////////////////////////////////////////////////////////////////////////////
	// Control word and channel list
	logic list_pending_q;
	logic restart;
	logic [1:0] wr_seq;

	assign wr_seq = {db_s[POS_LIST_ACC], db_s[POS_SCAN]};

	always_ff @(posedge clock) begin
		if (rst) begin
			control_word_q <= WORD_RESET;
			channel_list_q <= '0;
			list_pending_q <= 1'b0;
		end else if (wr_take) begin
			if (list_pending_q) begin
				channel_list_q <= db_s[LIST_W-1:0];
				list_pending_q <= 1'b0;
			end else begin
				control_word_q <= db_s;
				list_pending_q <= (wr_seq == SQ_LIST);
			end
		end
	end

	// A keep-mode write leaves the run alone; all others restart it
	assign restart = wr_take && (list_pending_q || wr_seq != SQ_KEEP);

	always_ff @(posedge clock) begin
		if (rst) begin
			run_mode_q <= SQ_OFF;
		end else if (wr_take) begin
			if (list_pending_q) begin
				run_mode_q <= SQ_LIST;
			end else if (wr_seq == SQ_OFF || wr_seq == SQ_CONSEC) begin
				run_mode_q <= wr_seq;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	// Field decode
	always_ff @(posedge clock) begin
		if (rst) begin
			coding_twos_q <= 1'b0;
			ref_internal_q <= 1'b0;
			range_double_q <= 1'b0;
			input_type_q <= IT_SINGLE;
		end else begin
			coding_twos_q <= control_word_q[POS_CODING];
			ref_internal_q <= control_word_q[POS_REF];
			range_double_q <= control_word_q[POS_RANGE];
			input_type_q <= control_word_q[POS_TYPE_HI:POS_TYPE_LO];
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	// Channel sequencer
	logic [2:0] final_ch;
	logic first_q;
	assign final_ch = control_word_q[POS_CH_HI:POS_CH_LO];

	function automatic logic [2:0] next_listed(input logic [LIST_W-1:0] list,
		input logic [2:0] cur, input logic first);
		logic [2:0] start;
		logic [2:0] idx;
		logic found;
		next_listed = cur;
		found = 1'b0;
		start = first ? 3'h0 : cur + 3'h1;
		for (int i = 0; i < LIST_W; i++) begin
			idx = start + 3'(i);
			if (!found && list[idx]) begin
				next_listed = idx;
				found = 1'b1;
			end
		end
	endfunction

	// Empty list keeps the last channel rather than stalling the trigger
	always_ff @(posedge clock) begin
		if (rst) begin
			conv_channel_q <= 3'h0;
			first_q <= 1'b1;
		end else if (restart) begin
			first_q <= 1'b1;
		end else if (trig_fall) begin
			first_q <= 1'b0;
			unique case (run_mode_q)
				SQ_OFF: conv_channel_q <= final_ch;
				SQ_LIST: conv_channel_q <= next_listed(channel_list_q, conv_channel_q, first_q);
				SQ_CONSEC: begin
					if (first_q || conv_channel_q >= final_ch) begin
						conv_channel_q <= 3'h0;
					end else begin
						conv_channel_q <= conv_channel_q + 3'h1;
					end
				end
				SQ_KEEP: conv_channel_q <= conv_channel_q;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	// Input pairing of the converted channel
	always_ff @(posedge clock) begin
		if (rst) begin
			vin_pos_q <= 3'h0;
			vin_neg_q <= 3'h0;
			vin_neg_agnd_q <= 1'b1;
			channel_illegal_q <= 1'b0;
		end else begin
			vin_pos_q <= conv_channel_q;
			channel_illegal_q <= 1'b0;
			unique case (input_type_q)
				IT_SINGLE: begin
					vin_neg_q <= 3'h0;
					vin_neg_agnd_q <= 1'b1;
				end
				IT_DIFF, IT_PSEUDO4: begin
					vin_neg_q <= conv_channel_q ^ 3'h1;
					vin_neg_agnd_q <= 1'b0;
				end
				IT_PSEUDO7: begin
					vin_neg_q <= 3'h7;
					vin_neg_agnd_q <= 1'b0;
					channel_illegal_q <= (conv_channel_q == 3'h7);
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	// Power control
	acw_pwr_if pif ();

	assign pif.mode = acw_power_mode_t'(control_word_q[POS_PWR_HI:POS_PWR_LO]);
	assign pif.ref_internal = control_word_q[POS_REF];
	assign pif.trig_fall = trig_fall;
	assign pif.conv_done = conv_done;

	acw_power u_power (
		.clock(clock),
		.rst(rst),
		.pif(pif)
	);

	always_ff @(posedge clock) begin
		if (rst) begin
			core_on_q <= 1'b1;
			ref_on_q <= 1'b1;
			ready_q <= 1'b1;
		end else begin
			core_on_q <= pif.core_on;
			ref_on_q <= pif.ref_on;
			ready_q <= pif.ready;
		end
	end

endmodule

// ==== acw_top_chk.sv ====
// Purpose: Port checker for acw_top
// Assumes: One clock, rst synchronous high
// Notes: Bound after the module
`timescale 1ns/1ns
module acw_top_chk
	import acw_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic conversion_trigger_n,
	input wire logic conv_done,
	input wire logic [WORD_W-1:0] control_word_q,
	input wire logic coding_twos_q,
	input wire logic ref_internal_q,
	input wire logic core_on_q,
	input wire logic ref_on_q,
	input wire logic ready_q
);
	logic wr_n_q;
	logic [3:0] gap_q;
	// Age of last selected strobe rise; saturates so it never wraps
	always_ff @(posedge clock) begin
		wr_n_q <= wr_n;
		if (rst) gap_q <= 4'hf;
		else if (!wr_n_q && wr_n && !cs_n) gap_q <= 4'h0;
		else if (gap_q != 4'hf) gap_q <= gap_q + 4'h1;
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_coding; $stable(control_word_q) |-> coding_twos_q == control_word_q[9]; endproperty
	a_coding: assert property (p_coding) else $error("coding output off");
	property p_ref; $stable(control_word_q) |-> ref_internal_q == control_word_q[8]; endproperty
	a_ref: assert property (p_ref) else $error("reference output off");
	property p_gate; $changed(control_word_q) |-> gap_q <= 4'h6; endproperty
	a_gate: assert property (p_gate) else $error("word changed without write");
	property p_full; control_word_q[11:10] == 2'b11 |-> ##[0:3] !core_on_q; endproperty
	a_full: assert property (p_full) else $error("full down not entered");
	property p_norm; control_word_q[11:10] == 2'b00 |-> ##[0:400] (core_on_q && ready_q); endproperty
	a_norm: assert property (p_norm) else $error("normal mode not up");
	property p_stby; control_word_q[11:10] == 2'b10 && $fell(core_on_q) |-> ref_on_q; endproperty
	a_stby: assert property (p_stby) else $error("standby lost reference");
	property p_auto; control_word_q[11:10] == 2'b01 && conv_done && ready_q |-> ##[1:3] !core_on_q;
	endproperty
	a_auto: assert property (p_auto) else $error("no power-down after done");
	property p_wake;
		control_word_q[11:10] == 2'b01 && !core_on_q && $fell(conversion_trigger_n)
		|-> ##[1:6] (core_on_q && !ready_q);
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on trigger");
	cover property (control_word_q[11:10] == 2'b11 && !core_on_q);
	cover property (control_word_q[11:10] == 2'b10 && !core_on_q && ref_on_q);
	cover property ($rose(ready_q));
endmodule
bind acw_top acw_top_chk chk (.*);

// ==== acw_host.sv ====
// Purpose: Host model for the parallel write pins and trigger
// Assumes: Called on falling edges
// Notes: Released bus shows inverted data, never the old word
`timescale 1ns/1ns
module acw_host
	import acw_pkg::*;
(
	input wire logic clock,
	output logic cs_n,
	output logic wr_n,
	output logic [WORD_W-1:0] db,
	output logic conversion_trigger_n
);
	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		db = 12'h000;
		conversion_trigger_n = 1'b1;
	end
	// Long holds since pins pass a two-stage sync
	task automatic wr(input logic [WORD_W-1:0] w, input logic sel);
		cs_n <= !sel;
		db <= w;
		repeat (4) @(negedge clock);
		wr_n <= 1'b0;
		repeat (4) @(negedge clock);
		wr_n <= 1'b1;
		repeat (4) @(negedge clock);
		cs_n <= 1'b1;
		db <= ~w;
		repeat (3) @(negedge clock);
	endtask
	task automatic trig();
		conversion_trigger_n <= 1'b0;
		repeat (4) @(negedge clock);
		conversion_trigger_n <= 1'b1;
		repeat (4) @(negedge clock);
	endtask
endmodule

// ==== test_adc_control_word_decode.sv ====
// Purpose: Self-checking bench for the control word decoder
// Assumes: Host model drives pins on falling edges
// Notes: Expectations queued, a watcher compares them
`timescale 1ns/1ns
module test_adc_control_word_decode;
	import acw_pkg::*;
	typedef struct {string nm; logic [11:0] e;} acw_note_t;
	logic clock, rst, conv_done, cs_n, wr_n, conversion_trigger_n;
	logic [WORD_W-1:0] db, control_word_q, w;
	logic [LIST_W-1:0] channel_list_q;
	logic coding_twos_q, ref_internal_q, range_double_q, vin_neg_agnd_q, channel_illegal_q;
	logic core_on_q, ref_on_q, ready_q;
	logic [1:0] input_type_q, run_mode_q;
	logic [2:0] conv_channel_q, vin_pos_q, vin_neg_q;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	acw_note_t notes[$];
	acw_note_t nt;
	event obs;
	acw_top uut (.*);
	acw_host host (.*);
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [11:0] act(string nm);
		case (nm)
			"w": return control_word_q;
			"cd": return 12'(coding_twos_q);
			"rf": return 12'(ref_internal_q);
			"ty": return 12'(input_type_q);
			"rg": return 12'(range_double_q);
			"ch": return 12'(conv_channel_q);
			"vp": return 12'(vin_pos_q);
			"ag": return 12'(vin_neg_agnd_q);
			"vn": return 12'(vin_neg_q);
			"il": return 12'(channel_illegal_q);
			"ls": return 12'(channel_list_q);
			"md": return 12'(run_mode_q);
			"co": return 12'(core_on_q);
			"ro": return 12'(ref_on_q);
			default: return 12'(ready_q);
		endcase
	endfunction
	task automatic note(string nm, logic [11:0] e);
		notes.push_back('{nm, e});
	endtask
	task automatic check(string nm, logic [11:0] seen, logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic obs_now();
		->obs;
		#1;
	endtask
	initial begin
		forever begin
			@obs;
			while (notes.size() > 0) begin
				nt = notes.pop_front();
				check(nt.nm, act(nt.nm), nt.e);
			end
		end
	end
	task automatic complete_run();
		if (miscompares == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic trigs(logic [15:0] ord);
		for (int i = 0; i < 4; i++) begin
			host.trig();
			note("ch", 12'(ord[15:12]));
			obs_now();
			ord = ord << 4;
		end
	endtask
	task automatic done_pulse();
		conv_done = 1'b1;
		@(negedge clock);
		conv_done = 1'b0;
		repeat (3) @(negedge clock);
	endtask
	initial begin
		rst = 1'b1;
		conv_done = 1'b0;
		w = 12'($urandom(22333));
		repeat (3) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		note("w", 12'h000);
		note("md", 12'h000);
		note("rd", 12'h001);
		obs_now();
		for (int i = 0; i < 10; i++) begin
			w = 12'($urandom) & 12'h3f9;
			// Pseudo mode with the top channel has no legal pair
			if (w[4:3] == 2'b11 && w[7:5] == 3'h7) w[5] = 1'b0;
			host.wr(w, 1'b1);
			note("w", w);
			note("cd", 12'(w[9]));
			note("rf", 12'(w[8]));
			note("ty", 12'(w[4:3]));
			note("rg", 12'(w[0]));
			host.trig();
			note("ch", 12'(w[7:5]));
			note("vp", 12'(w[7:5]));
			note("ag", 12'(w[4:3] == 2'b00));
			note("vn", w[4:3] == 2'b00 ? 12'h000 : w[4:3] == 2'b11 ? 12'h007 : 12'(w[7:5] ^ 3'h1));
			note("il", 12'h000);
			obs_now();
		end
		// Pseudo mode with the top channel has no legal pair
		host.wr(12'h0f8, 1'b1);
		host.trig();
		note("vn", 12'h007);
		note("il", 12'h001);
		obs_now();
		host.wr(12'h0e0, 1'b0);
		note("w", 12'h0f8);
		obs_now();
		host.wr(12'h046, 1'b1);
		note("md", 12'h003);
		trigs(16'h0120);
		host.wr(12'h242, 1'b1);
		host.trig();
		note("ch", 12'h001);
		note("md", 12'h003);
		note("cd", 12'h001);
		obs_now();
		host.wr(12'h004, 1'b1);
		host.wr(12'h0a4, 1'b1);
		note("ls", 12'h0a4);
		note("md", 12'h002);
		trigs(16'h2572);
		host.wr(12'h400, 1'b1);
		done_pulse();
		note("co", 12'h000);
		obs_now();
		host.trig();
		note("co", 12'h001);
		note("rd", 12'h000);
		obs_now();
		repeat (60) @(negedge clock);
		note("rd", 12'h001);
		obs_now();
		host.wr(12'h800, 1'b1);
		done_pulse();
		note("co", 12'h000);
		note("ro", 12'h001);
		obs_now();
		host.trig();
		note("rd", 12'h000);
		obs_now();
		repeat (40) @(negedge clock);
		note("rd", 12'h001);
		obs_now();
		host.wr(12'hf21, 1'b1);
		note("co", 12'h000);
		note("w", 12'hf21);
		obs_now();
		host.wr(12'h321, 1'b1);
		repeat (70) @(negedge clock);
		note("ro", 12'h001);
		note("rd", 12'h001);
		note("rg", 12'h001);
		obs_now();
		complete_run();
	end
endmodule
